// ==== power_mode_consts.vh ====
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH
// Register byte offsets
`define OFS_MODE_CONTROL 12'h000
`define OFS_WATCHDOG_CONTROL 12'h004
`define OFS_STATUS 12'h008
`define OFS_WAKE_ENABLE 12'h00c
`define OFS_COMMAND 12'h010
// Mode control fields
`define FLD_HIGH_LOW_CLOCK_SELECT 0
`define FLD_IDLE_EN 1
`define FLD_FAST_RDY 2
`define FLD_SLOW_RDY 3
`define FLD_SPARE 4
`define FLD_CKS_LO 5
`define FLD_CKS_HI 7
// Watchdog control fields
`define FLD_KEEP 7
`define FLD_WS_LO 4
`define FLD_WS_HI 6
// Status fields
`define FLD_PDF 0
`define FLD_TOF 1
`define FLD_MODE_LO 2
`define FLD_MODE_HI 4
// Command fields
`define FLD_CMD_HALT 0
`define FLD_CMD_CLRWDT1 1
`define FLD_CMD_CLRWDT2 2
// Reset values
`define RST_MODE_CONTROL 8'h03
`define RST_WATCHDOG_CONTROL 8'h7a
`define RST_WAKE_ENABLE 8'h00
// Divider select codes
`define CKS_SLOW_A 3'h0
`define CKS_SLOW_B 3'h1
// Operating modes
`define MODE_NORMAL 3'h0
`define MODE_SLOW 3'h1
`define MODE_SLEEP 3'h2
`define MODE_IDLE0 3'h3
`define MODE_IDLE1 3'h4
// Fast oscillator settle: 15 to 16 cycles, 16 used
`define FAST_SETTLE_CYCLES 5'h10
`endif

// ==== clock_divider.v ====
`timescale 1ns/1ns
`include "power_mode_consts.vh"
// Free divider of the fast oscillator; picks one tap as the system clock enable
module clock_divider (
   input wire clk,
   input wire srst,
   input wire run,
   input wire hiSel,
   input wire [2:0] divSel,
   output reg tick,
   output wire tap16,
   output wire tap64
);
   reg [5:0] cnt_reg; // Divide counter
   reg sel;
   // Tap taken for the chosen ratio
   always @* begin
      case (divSel)
         3'h2: sel = (cnt_reg == 6'h3f);
         3'h3: sel = (cnt_reg[4:0] == 5'h1f);
         3'h4: sel = (cnt_reg[3:0] == 4'hf);
         3'h5: sel = (cnt_reg[2:0] == 3'h7);
         3'h6: sel = (cnt_reg[1:0] == 2'h3);
         3'h7: sel = cnt_reg[0];
         default: sel = 1'b0;
      endcase
   end
   // Counter stops with the oscillator, taking both internal taps along
   always @(posedge clk) begin
      if (srst || !run) begin
         cnt_reg <= 6'h00;
         tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 6'h01;
         tick <= hiSel ? 1'b1 : sel;
      end
   end
   assign tap16 = run & (cnt_reg[3:0] == 4'hf);
   assign tap64 = run & (cnt_reg == 6'h3f);
endmodule

// ==== watchdog_counter.v ====
`timescale 1ns/1ns
`include "power_mode_consts.vh"
// Watchdog count on slow oscillator ticks; overflow at 2^(8+ws)
module watchdog_counter (
   input wire clk,
   input wire srst,
   input wire slowTick,
   input wire clear,
   input wire [2:0] ws,
   output reg overflow
);
   reg [15:0] cnt_reg; // Count of slow ticks
   wire [15:0] limit;
   assign limit = (16'h0100 << ws) - 16'h0001;
   // Clear restarts counting at once; counter runs in every mode
   always @(posedge clk) begin
      if (srst || clear) begin
         cnt_reg <= 16'h0000;
         overflow <= 1'b0;
      end else if (slowTick) begin
         overflow <= (cnt_reg == limit);
         cnt_reg <= (cnt_reg == limit) ? 16'h0000 : cnt_reg + 16'h0001;
      end else begin
         overflow <= 1'b0;
      end
   end
endmodule

// ==== power_mode_controller.v ====
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`include "power_mode_consts.vh"
// Summary of operation
// - NORMAL runs CPU from fast clock, divided or undivided
// - SLOW runs from slow osc, fast off
// - HALT with idle off enters SLEEP
// - Slow osc keeps watchdog counting in SLEEP
// - HALT idle, no keep enters IDLE0
// - IDLE0 keeps time-base and slow clocks
// - HALT idle with keep enters IDLE1
// - Fast osc and its taps stop when unused
// - Low-power entry preserves memory, registers, ports
// - HALT entry clears watchdog, then resumes
// - HALT entry sets power-down, clears timeout
// - Wake on reset, port fall, interrupt, watchdog
// - Reset wake full reset; watchdog wake resets PC and SP
// - Power-down flag cleared by clear instructions, set by HALT
// - Sleep timeout sets flag, resets PC and SP
// - Divide select picks slow or fast/64..fast/2
// - Fast ready returns 15-16 cycles after wake
// - Per-pin port wake enable on falling edge
module power_mode_controller (
   input wire clk,
   input wire srst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire slowTick,
   input wire extResetWake,
   input wire [7:0] portA,
   input wire sysIrq,
   output reg cpuRun,
   output reg sysClkEn,
   output reg timeBaseClkEn,
   output wire slowOscOn,
   output reg fastOscOn,
   output wire fastTap16,
   output wire fastTap64,
   output reg fullReset,
   output reg watchdogReset,
   output reg pcSpReset
);
   // Software-visible control words
   reg [7:0] modeCtl_reg; // mode_control_reg contents
   reg [7:0] wdtCtl_reg; // watchdog_control_reg contents
   reg [7:0] wakeEn_reg; // porta_wake_enable
   // Status flags seen in the status word
   reg powerDown_reg; // power_down_flag
   reg timeout_reg; // watchdog_timeout_flag
   // Operating mode and its next value
   reg [2:0] mode_reg; // Current operating mode
   reg [2:0] mode_next;
   // Fast oscillator start-up tracking
   reg [4:0] settle_reg; // Fast oscillator settle counter
   reg fastRdy_reg; // fast_osc_ready
   // Port A edge history
   reg [7:0] portPrev_reg; // Port A previous level
   // Bus data phase bookkeeping
   reg wrPend_reg; // Write data phase pending
   reg rdPend_reg; // Read data phase pending
   reg [11:0] addr_reg; // Latched address
   // Alternation memory of the clear instructions
   reg clr1Last_reg; // Last clear instruction was the first kind
   // Decoded bus and command strobes
   wire addrPhase;
   wire haltCmd;
   wire clrWdt1;
   wire clrWdt2;
   wire clrWdtOk;
   // Watchdog and clock needs
   wire wdtOverflow;
   wire fastTick;
   wire wantFast;
   wire lowPower;
   // Wake-up sources and watchdog clear
   wire [7:0] portFall;
   wire wakePort;
   wire wake;
   wire wdtClear;
   wire [2:0] cks;

   // Divide select field of the mode control word
   assign cks = modeCtl_reg[`FLD_CKS_HI:`FLD_CKS_LO];
   // Address phase taken when selected, ready and non-idle
   assign addrPhase = hsel && hready && htrans[1];
   // Zero wait states: every transfer completes at once
   assign hreadyout = 1'b1;
   // Response is always OKAY
   assign hresp = 1'b0;
   // Software commands arrive as writes to the command word
   // Each command is a one-cycle strobe in the data phase
   assign haltCmd = wrPend_reg && (addr_reg == `OFS_COMMAND) && hwdata[`FLD_CMD_HALT];
   assign clrWdt1 = wrPend_reg && (addr_reg == `OFS_COMMAND) && hwdata[`FLD_CMD_CLRWDT1];
   assign clrWdt2 = wrPend_reg && (addr_reg == `OFS_COMMAND) && hwdata[`FLD_CMD_CLRWDT2];
   // Clear instructions act only when alternated
   assign clrWdtOk = (clrWdt1 && !clr1Last_reg) || (clrWdt2 && clr1Last_reg);
   // SLEEP, IDLE0 and IDLE1 all count as low power
   assign lowPower = (mode_reg == `MODE_SLEEP) || (mode_reg == `MODE_IDLE0) ||
                     (mode_reg == `MODE_IDLE1);
   // Fast osc needed by select bit or fast divide code
   assign wantFast = modeCtl_reg[`FLD_HIGH_LOW_CLOCK_SELECT] ||
                     ((cks != `CKS_SLOW_A) && (cks != `CKS_SLOW_B));
   // Falling edge on an enabled pin only
   assign portFall = portPrev_reg & ~portA & wakeEn_reg;
   assign wakePort = |portFall;
   // Any source ends a low-power mode
   assign wake = extResetWake || wakePort || sysIrq || wdtOverflow;
   // Watchdog restarts on HALT entry, on an accepted clear
   // and on an external reset request
   assign wdtClear = (haltCmd && !lowPower) || clrWdtOk || extResetWake;
   // Slow oscillator has no off switch
   assign slowOscOn = 1'b1;

   // Fast clock divider
   clock_divider divider (
      .clk(clk),
      .srst(srst),
      .run(fastOscOn),
      .hiSel(modeCtl_reg[`FLD_HIGH_LOW_CLOCK_SELECT]),
      .divSel(cks),
      .tick(fastTick),
      .tap16(fastTap16),
      .tap64(fastTap64)
   );

   // Watchdog on the always-on slow oscillator
   watchdog_counter watchdog (
      .clk(clk),
      .srst(srst),
      .slowTick(slowTick),
      .clear(wdtClear),
      .ws(wdtCtl_reg[`FLD_WS_HI:`FLD_WS_LO]),
      .overflow(wdtOverflow)
   );

   // Next mode: HALT entry and wake
   always @* begin
      mode_next = mode_reg;
      // Low power: stay until a wake source fires
      if (lowPower) begin
         // Wake returns to the mode the select bits ask for
         if (wake) begin
            mode_next = wantFast ? `MODE_NORMAL : `MODE_SLOW;
         end
      end else if (haltCmd) begin
         // Running: HALT picks the low-power mode
         if (!modeCtl_reg[`FLD_IDLE_EN]) begin
            mode_next = `MODE_SLEEP;
         end else if (!wdtCtl_reg[`FLD_KEEP]) begin
            mode_next = `MODE_IDLE0;
         end else begin
            mode_next = `MODE_IDLE1;
         end
      end else begin
         // Running without HALT: select bits pick NORMAL or SLOW
         mode_next = wantFast ? `MODE_NORMAL : `MODE_SLOW;
      end
   end

   // Clock gating per mode
   always @* begin
      // Defaults: everything stopped but the time base
      cpuRun = 1'b0;
      sysClkEn = 1'b0;
      timeBaseClkEn = 1'b1;
      fastOscOn = 1'b0;
      case (mode_reg)
         `MODE_NORMAL: begin
            cpuRun = 1'b1;
            sysClkEn = fastTick;
            fastOscOn = 1'b1;
         end
         `MODE_SLOW: begin
            // Fast oscillator stays off while running slow
            cpuRun = 1'b1;
            sysClkEn = slowTick;
         end
         `MODE_SLEEP: begin
            timeBaseClkEn = 1'b0;
         end
         `MODE_IDLE0: begin
            timeBaseClkEn = 1'b1;
         end
         default: begin
            // IDLE1: CPU stopped, system clock keeps peripherals going
            // Fast oscillator runs here only when the select bits ask for it
            sysClkEn = wantFast ? fastTick : slowTick;
            fastOscOn = wantFast;
         end
      endcase
   end

   // Mode, flags, resets and bus registers
   always @(posedge clk) begin
      if (srst) begin
         // Every register to its power-on value
         mode_reg <= `MODE_NORMAL;
         modeCtl_reg <= `RST_MODE_CONTROL;
         wdtCtl_reg <= `RST_WATCHDOG_CONTROL;
         wakeEn_reg <= `RST_WAKE_ENABLE;
         powerDown_reg <= 1'b0;
         timeout_reg <= 1'b0;
         settle_reg <= 5'h00;
         fastRdy_reg <= 1'b0;
         portPrev_reg <= 8'h00;
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         addr_reg <= 12'h000;
         clr1Last_reg <= 1'b0;
         fullReset <= 1'b0;
         watchdogReset <= 1'b0;
         pcSpReset <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         mode_reg <= mode_next;
         portPrev_reg <= portA;
         wrPend_reg <= addrPhase && hwrite;
         rdPend_reg <= addrPhase && !hwrite;
         // Latch the address for the data phase
         if (addrPhase) begin
            addr_reg <= haddr[11:0];
         end
         // Register writes hold during low power, nothing else disturbed
         if (wrPend_reg) begin
            // Status word is read-only; writes to it are dropped
            if (addr_reg == `OFS_MODE_CONTROL) begin
               // Spare bit is plain storage; ready bits are read-only
               modeCtl_reg[`FLD_HIGH_LOW_CLOCK_SELECT] <= hwdata[`FLD_HIGH_LOW_CLOCK_SELECT];
               modeCtl_reg[`FLD_IDLE_EN] <= hwdata[`FLD_IDLE_EN];
               modeCtl_reg[`FLD_SPARE] <= hwdata[`FLD_SPARE];
               modeCtl_reg[`FLD_CKS_HI:`FLD_CKS_LO] <= hwdata[`FLD_CKS_HI:`FLD_CKS_LO];
            end else if (addr_reg == `OFS_WATCHDOG_CONTROL) begin
               wdtCtl_reg <= hwdata[7:0];
            end else if (addr_reg == `OFS_WAKE_ENABLE) begin
               wakeEn_reg <= hwdata[7:0];
            end
         end
         // Clear instructions must alternate to take effect
         if (clrWdt1) begin
            clr1Last_reg <= 1'b1;
         end else if (clrWdt2) begin
            clr1Last_reg <= 1'b0;
         end
         // Flags: HALT sets power-down and clears timeout
         if (haltCmd && !lowPower) begin
            powerDown_reg <= 1'b1;
            timeout_reg <= 1'b0;
         end else if (clrWdtOk) begin
            powerDown_reg <= 1'b0;
            timeout_reg <= 1'b0;
         end
         // Timeout set wins over a HALT clear in the same cycle
         if (wdtOverflow) begin
            timeout_reg <= 1'b1;
         end
         // Reset pulses on wake
         // Each pulse lasts one cycle, as overflow is one cycle long and a wake leaves low power at once
         fullReset <= lowPower && extResetWake;
         watchdogReset <= !lowPower && wdtOverflow;
         pcSpReset <= lowPower && wdtOverflow && !extResetWake;
         // Fast ready falls while off and after SLEEP/IDLE0, rises after settle
         if (!fastOscOn) begin
            settle_reg <= 5'h00;
            fastRdy_reg <= 1'b0;
         end else if (settle_reg != `FAST_SETTLE_CYCLES) begin
            // Ready returns only after the full settle count
            settle_reg <= settle_reg + 5'h01;
            fastRdy_reg <= (settle_reg == `FAST_SETTLE_CYCLES - 5'h01);
         end
         // Read data
         // Unmapped addresses read as zero
         if (addrPhase && !hwrite) begin
            hrdata <= 32'h00000000;
            if (haddr[11:0] == `OFS_MODE_CONTROL) begin
               hrdata[7:0] <= {cks, modeCtl_reg[`FLD_SPARE], 1'b1, fastRdy_reg,
                               modeCtl_reg[`FLD_IDLE_EN], modeCtl_reg[`FLD_HIGH_LOW_CLOCK_SELECT]};
            end else if (haddr[11:0] == `OFS_WATCHDOG_CONTROL) begin
               hrdata[7:0] <= wdtCtl_reg;
            end else if (haddr[11:0] == `OFS_STATUS) begin
               hrdata[4:0] <= {mode_reg, timeout_reg, powerDown_reg};
            end else if (haddr[11:0] == `OFS_WAKE_ENABLE) begin
               hrdata[7:0] <= wakeEn_reg;
            end
         end
      end
   end
   // no state is touched on low-power entry besides the flags above, the watchdog count and fast ready when the fast osc stops
   // software polls fast ready in the mode control word
   // Mode changes on the edge that ends the command's data phase
   // Watchdog period is counted in slow ticks, so it holds in every mode
endmodule

// ==== power_mode_sva.sv ====
`timescale 1ns/1ns
// Port-level checks of clock gating, oscillators and wake-up
module power_mode_sva (
   input wire clk,
   input wire srst,
   input wire hreadyout,
   input wire hresp,
   input wire sysIrq,
   input wire extResetWake,
   input wire cpuRun,
   input wire sysClkEn,
   input wire timeBaseClkEn,
   input wire slowOscOn,
   input wire fastOscOn,
   input wire fastTap16,
   input wire fastTap64,
   input wire fullReset,
   input wire watchdogReset,
   input wire pcSpReset
);
   // One clock domain, sync reset disables every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Zero wait states, always OKAY
   a_bus_okay_now: assert property (hreadyout && !hresp)
      else $error("bus wait or error response");
   a_slow_osc_on: assert property (slowOscOn)
      else $error("slow oscillator stopped");
   a_sleep_gates_all: assert property (!timeBaseClkEn |-> !cpuRun && !sysClkEn && !fastOscOn)
      else $error("clock still running in sleep");
   a_taps_stop: assert property (!fastOscOn |-> !fastTap16 && !fastTap64)
      else $error("fast tap runs with oscillator off");
   a_run_timebase: assert property (cpuRun |-> timeBaseClkEn)
      else $error("time base off while running");
   a_irq_wakes: assert property ($rose(sysIrq) && !cpuRun |-> ##[1:4] cpuRun)
      else $error("interrupt did not wake");
   a_ext_wake_reset: assert property ($rose(extResetWake) && !cpuRun |-> ##[1:3] fullReset)
      else $error("external wake without full reset");
   a_wdt_halted_pcsp: assert property (pcSpReset |-> !$past(cpuRun))
      else $error("pc and sp reset outside low power");
   a_wdt_run_reset: assert property (watchdogReset |-> $past(cpuRun))
      else $error("watchdog reset inside low power");
   // Main scenarios reached
   c_sleep: cover property (!timeBaseClkEn);
   c_halt_timeout: cover property (pcSpReset);
   c_full_reset: cover property (fullReset);
endmodule
bind power_mode_controller power_mode_sva i_power_mode_sva (.clk(clk), .srst(srst),
   .hreadyout(hreadyout), .hresp(hresp), .sysIrq(sysIrq), .extResetWake(extResetWake),
   .cpuRun(cpuRun), .sysClkEn(sysClkEn), .timeBaseClkEn(timeBaseClkEn), .slowOscOn(slowOscOn),
   .fastOscOn(fastOscOn), .fastTap16(fastTap16), .fastTap64(fastTap64), .fullReset(fullReset),
   .watchdogReset(watchdogReset), .pcSpReset(pcSpReset));

// ==== power_mode_controller_tb.sv ====
`timescale 1ns/1ns
module power_mode_controller_tb;
   // Stimulus, all given a value at time zero
   logic clk = 0, srst = 1, hsel = 0, hwrite = 0, extResetWake = 0, sysIrq = 0, slowTick = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0] htrans = 0, tickDiv = 0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] portA = 8'hff;
   wire [31:0] hrdata;
   wire hreadyout, hresp, cpuRun, sysClkEn, timeBaseClkEn, slowOscOn, fastOscOn;
   wire fastTap16, fastTap64, fullReset, watchdogReset, pcSpReset;
   int numErrors = 0, nCompared = 0, cnt, expv;
   power_mode_controller i_power_mode_controller (.clk(clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .slowTick(slowTick), .extResetWake(extResetWake), .portA(portA), .sysIrq(sysIrq),
      .cpuRun(cpuRun), .sysClkEn(sysClkEn), .timeBaseClkEn(timeBaseClkEn),
      .slowOscOn(slowOscOn), .fastOscOn(fastOscOn), .fastTap16(fastTap16),
      .fastTap64(fastTap64), .fullReset(fullReset), .watchdogReset(watchdogReset),
      .pcSpReset(pcSpReset));
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   // Slow oscillator tick every fourth cycle
   always @(posedge clk) begin
      tickDiv <= tickDiv + 2'h1;
      slowTick <= (tickDiv == 2'h3);
   end
   // Compare and count
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nCompared++;
      if (g !== e) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One AHB single transfer; read data lands in rd
   task bus(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 0;
   endtask
   task rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(nm, {24'h0, e}, rd);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // System clock enables seen over n cycles
   task count_clk(input int n);
      cnt = 0;
      repeat (n) begin
         @(posedge clk);
         if (sysClkEn === 1'b1) cnt++;
      end
      #1;
   endtask
   // Bounded wait for the CPU to run again
   task wake_wait;
      cnt = 0;
      while (cpuRun !== 1'b1 && cnt < 20) begin
         @(posedge clk);
         cnt++;
      end
      #1;
      chk("cpuRun", 1, cpuRun);
   endtask
   // Set control, halt, check entry effects
   task halt_in(input logic [7:0] ctl, input logic [7:0] wdc, input logic [2:0] m);
      bus(12'h000, 1'b1, ctl);
      bus(12'h004, 1'b1, wdc);
      bus(12'h010, 1'b1, 8'h01);
      cyc(4);
      chk("cpuRun halted", 0, cpuRun);
      rdchk("status", 12'h008, {3'h0, m, 2'h1});
      rdchk("wdCtl kept", 12'h004, wdc);
   endtask
   task irq_wake;
      @(posedge clk);
      sysIrq <= 1;
      wake_wait;
      @(posedge clk);
      sysIrq <= 0;
   endtask
   // Reset values, read-only and unmapped places
   task t_reset;
      cyc(30);
      rdchk("modeCtl", 12'h000, 8'h0f);
      rdchk("wdCtl", 12'h004, 8'h7a);
      bus(12'h008, 1'b1, 8'hff);
      rdchk("status", 12'h008, 8'h00);
      rdchk("wakeEn", 12'h00c, 8'h00);
      rdchk("unmapped", 12'h040, 8'h00);
   endtask
   // Every divide code, then undivided fast clock
   task t_clocks;
      for (int c = 0; c < 9; c++) begin
         bus(12'h000, 1'b1, (c == 8) ? 8'h01 : {c[2:0], 5'h00});
         cyc(40);
         count_clk(128);
         expv = (c == 8) ? 128 : (c < 2) ? 32 : (128 >> (8 - c));
         chk("sysClkEn count", expv, cnt);
         chk("fastOscOn", c > 1, fastOscOn);
         rdchk("mode", 12'h008, (c > 1) ? 8'h00 : 8'h04);
      end
   endtask
   // Sleep, idle0 and idle1 entry and wake
   task t_modes;
      halt_in(8'h01, 8'h7a, 3'h2);
      chk("timeBase sleep", 0, timeBaseClkEn);
      irq_wake;
      rdchk("fast ready low", 12'h000, 8'h09);
      cyc(16);
      rdchk("fast ready", 12'h000, 8'h0d);
      rdchk("status", 12'h008, 8'h01);
      bus(12'h010, 1'b1, 8'h02);
      rdchk("status cleared", 12'h008, 8'h00);
      halt_in(8'h03, 8'h7a, 3'h3);
      chk("timeBase idle0", 1, timeBaseClkEn);
      count_clk(64);
      chk("sysClk idle0", 0, cnt);
      irq_wake;
      halt_in(8'h03, 8'hfa, 3'h4);
      count_clk(64);
      chk("sysClk idle1", 64, cnt);
      irq_wake;
   endtask
   // Only enabled port pins wake
   task t_port;
      bus(12'h00c, 1'b1, 8'h04);
      halt_in(8'h01, 8'h7a, 3'h2);
      @(posedge clk);
      portA <= 8'hfe;
      cyc(10);
      chk("masked pin", 0, cpuRun);
      @(posedge clk);
      portA <= 8'hfa;
      wake_wait;
      @(posedge clk);
      portA <= 8'hff;
   endtask
   // External reset wake gives one full reset
   task t_ext;
      halt_in(8'h01, 8'h7a, 3'h2);
      @(posedge clk);
      extResetWake <= 1;
      @(posedge clk);
      extResetWake <= 0;
      count_clk(0);
      repeat (5) begin
         @(posedge clk);
         if (fullReset === 1'b1) cnt++;
      end
      chk("fullReset pulses", 1, cnt);
      wake_wait;
   endtask
   // Halt clears the watchdog; timeouts inside and outside low power
   task t_wdt;
      bus(12'h004, 1'b1, 8'h00);
      cyc(600);
      halt_in(8'h01, 8'h00, 3'h2);
      cnt = 0;
      repeat (900) begin
         @(posedge clk);
         if (pcSpReset === 1'b1) cnt++;
      end
      chk("early timeout", 0, cnt);
      cnt = 0;
      while (pcSpReset !== 1'b1 && cnt < 300) begin
         @(posedge clk);
         cnt++;
      end
      chk("pcSpReset", 1, pcSpReset);
      wake_wait;
      rdchk("status timeout", 12'h008, 8'h03);
      cnt = 0;
      while (watchdogReset !== 1'b1 && cnt < 1200) begin
         @(posedge clk);
         cnt++;
      end
      chk("watchdogReset", 1, watchdogReset);
   endtask
   // Verdict and end of run
   task conclude;
      if (numErrors == 0 && nCompared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      srst <= 0;
      t_reset;
      t_clocks;
      t_modes;
      t_port;
      t_ext;
      t_wdt;
      conclude;
   end
   // Hang guard
   initial begin
      repeat (40000) @(posedge clk);
      numErrors++;
      conclude;
   end
endmodule
